// file: hw/fsl_defs.svh
// Constants for the flash security interlock
`ifndef FSL_DEFS_SVH
`define FSL_DEFS_SVH
`define FSL_AW          16
`define FSL_DW          16
`define FSL_SEC_ADDR    16'h1FF7
`define FSL_KEY_BASE    16'h1FFC
`define FSL_SEC_ON      16'h0002
`define FSL_SEC_OFF     16'h0000
`define FSL_ERASED      16'hFFFF
`define FSL_NWORDS      5
`define FSL_IDX_W       3
`define FSL_LAST_IDX    3'h4
`define FSL_KEY_LAST    2'h3
`define FSL_IR_W        4
`define FSL_IR_IDCODE   4'h1
`define FSL_IR_SAMPLE   4'h2
`define FSL_IR_ERASE    4'hB
`define FSL_IR_BYPASS   4'hF
`define FSL_IR_CAPTURE  4'h1
`define FSL_DIV_W       7
`define FSL_BSR_W       8
`define FSL_ID_W        32
`define FSL_IDCODE_VAL  32'h0000_1001
`define FSL_TLR_ONES    3'h5
`endif

// file: hw/fsl_pkg.sv
// Types for the flash security interlock
`include "fsl_defs.svh"
package fsl_pkg;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PA_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UP_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE,
    TAP_EX1_IR = 4'hA, TAP_PA_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UP_IR = 4'h8
  } fsl_tap_t;
  typedef enum logic [1:0] {
    BOOT_READ = 2'b00, BOOT_WAIT = 2'b01, BOOT_DONE = 2'b11
  } fsl_boot_t;
  typedef struct packed {
    logic                valid;
    logic [`FSL_AW-1:0]  addr;
    logic [`FSL_DW-1:0]  data;
  } fsl_req_t;
endpackage

// file: hw/fsl_lockout.sv
// Flash security interlock: security word, debug gate, lockout erase, back-door key
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defs.svh"
module fsl_lockout
  import fsl_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                dev_rstn,
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe_n,
  input  wire logic [`FSL_BSR_W-1:0] bsr_pins,
  output logic                     fl_rd_req,
  output logic [`FSL_AW-1:0]       fl_rd_addr,
  input  wire logic                fl_rd_ack,
  input  wire logic [`FSL_DW-1:0]  fl_rd_data,
  input  wire fsl_req_t            cpu_prog,
  output fsl_req_t                 fl_prog,
  output logic                     erase_go,
  output logic [`FSL_DIV_W-1:0]    erase_div,
  input  wire logic                erase_done,
  output logic                     prot_clr,
  input  wire logic                cpu_acc,
  input  wire logic                cpu_key,
  input  wire logic [`FSL_DW-1:0]  cpu_wdata,
  input  wire logic                dbg_fl_req,
  output logic                     dbg_fl_grant,
  output logic                     dbg_fl_denied,
  output logic                     dbg_en,
  output logic                     secured
);
  // ****************************************
  // Declarations
  // ****************************************
  logic                    dev_rst;
  logic [2:0]              tck_r;
  logic [1:0]              tms_r;
  logic [1:0]              tdi_r;
  logic                    tck_rise;
  logic                    tck_fall;
  fsl_tap_t                tap_r;
  fsl_tap_t                tap_nxt;
  logic [`FSL_BSR_W-1:0]   bsr_s1_r;
  logic [`FSL_BSR_W-1:0]   bsr_s2_r;
  logic [`FSL_IR_W-1:0]    ir_r;
  logic [`FSL_IR_W-1:0]    irsh_r;
  logic [`FSL_ID_W-1:0]    dr_r;
  logic [`FSL_DIV_W-1:0]   div_r;
  logic                    armed_r;
  logic                    erase_busy_r;
  logic                    erase_fin_r;
  fsl_boot_t               boot_r;
  logic [`FSL_IDX_W-1:0]   idx_r;
  logic [`FSL_DW-1:0]      word_r [0:`FSL_NWORDS-1];
  logic                    sec_r;
  logic                    bd_unlock_r;
  logic [1:0]              kcnt_r;
  logic                    kok_r;
  logic                    key_hit;
  logic                    key_last;
  logic                    boot_done;

  assign dev_rst   = !resetn || !dev_rstn;
  assign boot_done = (boot_r == BOOT_DONE);

  // ****************************************
  // Pin synchronisers and TCK edges
  // ****************************************
  // Two flops per pin, three on TCK; edge detect reads only the second stage onward
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tck_r    <= 3'h7; // Idle-high level, so release shows no false edge
      tms_r    <= 2'h3;
      tdi_r    <= 2'h0;
      bsr_s1_r <= '0;
      bsr_s2_r <= '0;
    end
    else
    begin
      tck_r    <= {tck_r[1:0], tck};
      tms_r    <= {tms_r[0], tms};
      tdi_r    <= {tdi_r[0], tdi};
      bsr_s1_r <= bsr_pins;
      bsr_s2_r <= bsr_s1_r;
    end
  end
  assign tck_rise = tck_r[1] && !tck_r[2];
  assign tck_fall = !tck_r[1] && tck_r[2];

  // ****************************************
  // TAP controller (reset only by power-on or five TMS ones)
  // ****************************************
  // Next-state walk of the standard TAP graph
  always_comb
  begin
    tap_nxt = tap_r;
    unique case (tap_r)
      TAP_RESET:  tap_nxt = tms_r[1] ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_nxt = tms_r[1] ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_nxt = tms_r[1] ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_nxt = tms_r[1] ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_nxt = tms_r[1] ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_nxt = tms_r[1] ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_nxt = tms_r[1] ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_nxt = tms_r[1] ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_nxt = tms_r[1] ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_nxt = tms_r[1] ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_nxt = tms_r[1] ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_nxt = tms_r[1] ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_nxt = tms_r[1] ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_nxt = tms_r[1] ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_nxt = tms_r[1] ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_nxt = tms_r[1] ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // State register; power-on reset forces Test-Logic-Reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
      tap_r <= TAP_RESET;
    else if (tck_rise)
      tap_r <= tap_nxt;
  end

  // Instruction register, independent of security state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ir_r   <= `FSL_IR_IDCODE;
      irsh_r <= `FSL_IR_CAPTURE;
    end
    else if (tck_rise)
    begin
      if (tap_r == TAP_RESET)
        ir_r <= `FSL_IR_IDCODE;
      else if (tap_r == TAP_UP_IR)
        ir_r <= irsh_r;
      if (tap_r == TAP_CAP_IR)
        irsh_r <= `FSL_IR_CAPTURE;
      else if (tap_r == TAP_SH_IR)
        irsh_r <= {tdi_r[1], irsh_r[`FSL_IR_W-1:1]};
    end
  end

  // Data shift path: ID, boundary sample, divider or bypass
  always_ff @(posedge clk)
  begin
    if (!resetn)
      dr_r <= '0;
    else if (tck_rise && tap_r == TAP_CAP_DR)
    begin
      unique case (ir_r)
        `FSL_IR_IDCODE: dr_r <= `FSL_IDCODE_VAL;
        `FSL_IR_SAMPLE: dr_r <= {{(`FSL_ID_W-`FSL_BSR_W){1'b0}}, bsr_s2_r};
        `FSL_IR_ERASE:  dr_r <= {{(`FSL_ID_W-`FSL_DIV_W){1'b0}}, div_r};
        default:        dr_r <= '0;
      endcase
    end
    else if (tck_rise && tap_r == TAP_SH_DR)
    begin
      unique case (ir_r)
        `FSL_IR_IDCODE: dr_r <= {tdi_r[1], dr_r[`FSL_ID_W-1:1]};
        `FSL_IR_SAMPLE: dr_r <= {{(`FSL_ID_W-`FSL_BSR_W){1'b0}}, tdi_r[1],
                                 dr_r[`FSL_BSR_W-1:1]};
        `FSL_IR_ERASE:  dr_r <= {{(`FSL_ID_W-`FSL_DIV_W){1'b0}}, tdi_r[1],
                                 dr_r[`FSL_DIV_W-1:1]};
        default:        dr_r <= {{(`FSL_ID_W-1){1'b0}}, tdi_r[1]};
      endcase
    end
  end

  // TDO changes on falling TCK, driven only while shifting
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo      <= (tap_r == TAP_SH_IR) ? irsh_r[0] : dr_r[0];
      tdo_oe_n <= !(tap_r == TAP_SH_IR || tap_r == TAP_SH_DR);
    end
  end

  // ****************************************
  // Lockout erase
  // ****************************************
  // Divider latches on Update-DR; erase is armed until Run-Test/Idle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      div_r   <= '0;
      armed_r <= 1'b0;
    end
    else if (tck_rise)
    begin
      if (tap_r == TAP_UP_DR && ir_r == `FSL_IR_ERASE)
      begin
        div_r   <= dr_r[`FSL_DIV_W-1:0];
        armed_r <= 1'b1;
      end
      else if (tap_r == TAP_RESET || ir_r != `FSL_IR_ERASE)
        armed_r <= 1'b0;
      else if (tap_r == TAP_IDLE)
        armed_r <= 1'b0;
    end
  end

  // Erase runs while the TAP sits in Run-Test/Idle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      erase_busy_r <= 1'b0;
      erase_fin_r  <= 1'b0;
      prot_clr     <= 1'b0;
    end
    else
    begin
      prot_clr <= 1'b0;
      if (erase_busy_r && erase_done)
      begin
        erase_busy_r <= 1'b0;
        erase_fin_r  <= 1'b1;
        prot_clr     <= 1'b1;
      end
      else if (armed_r && tap_r == TAP_IDLE && !erase_fin_r)
        erase_busy_r <= 1'b1;
      else if (tap_r != TAP_IDLE)
        erase_busy_r <= 1'b0;
    end
  end
  assign erase_go  = erase_busy_r;
  assign erase_div = div_r;

  // ****************************************
  // Boot read of security word and key words
  // ****************************************
  // Reads index 0 (security word) then four key words after each reset
  always_ff @(posedge clk)
  begin
    if (dev_rst)
    begin
      boot_r <= BOOT_READ;
      idx_r  <= '0;
    end
    else
    begin
      unique case (boot_r)
        BOOT_READ: boot_r <= BOOT_WAIT;
        BOOT_WAIT:
          if (fl_rd_ack)
          begin
            if (idx_r == `FSL_LAST_IDX)
              boot_r <= BOOT_DONE;
            else
            begin
              idx_r  <= idx_r + 3'h1;
              boot_r <= BOOT_READ;
            end
          end
        BOOT_DONE: boot_r <= BOOT_DONE;
      endcase
    end
  end
  assign fl_rd_req  = (boot_r == BOOT_READ);
  assign fl_rd_addr = (idx_r == '0) ? `FSL_SEC_ADDR
                    : `FSL_KEY_BASE + {{(`FSL_AW-`FSL_IDX_W){1'b0}}, idx_r - 3'h1};

  // Word copies: filled at boot, forced to erased once a lockout erase finishes, otherwise bits only cleared by programming
  genvar gi;
  generate
    for (gi = 0; gi < `FSL_NWORDS; gi++)
    begin : g_word
      localparam logic [`FSL_AW-1:0] WADDR = (gi == 0) ? `FSL_SEC_ADDR
                                           : `FSL_KEY_BASE + `FSL_AW'(gi - 1);
      always_ff @(posedge clk)
      begin
        if (dev_rst)
          word_r[gi] <= `FSL_ERASED;
        else if (boot_r == BOOT_WAIT && fl_rd_ack && idx_r == `FSL_IDX_W'(gi))
          word_r[gi] <= fl_rd_data;
        else if (erase_fin_r)
          word_r[gi] <= `FSL_ERASED;
        else if (cpu_prog.valid && cpu_prog.addr == WADDR)
          word_r[gi] <= word_r[gi] & cpu_prog.data;
      end
    end
  endgenerate

  // Program path: a write can only pull bits low in the security word; other writes pass unmasked
  always_ff @(posedge clk)
  begin
    if (dev_rst)
      fl_prog <= '0;
    else
    begin
      fl_prog.valid <= cpu_prog.valid;
      fl_prog.addr  <= cpu_prog.addr;
      if (cpu_prog.addr == `FSL_SEC_ADDR)
        fl_prog.data <= cpu_prog.data & word_r[0];
      else
        fl_prog.data <= cpu_prog.data;
    end
  end

  // Security is latched once per reset from the security word
  always_ff @(posedge clk)
  begin
    if (dev_rst)
      sec_r <= 1'b1;
    else if (boot_r == BOOT_WAIT && fl_rd_ack && idx_r == '0)
      sec_r <= (fl_rd_data == `FSL_SEC_ON);
  end

  // ****************************************
  // Back-door key
  // ****************************************
  // Index widened so the fourth key word does not wrap onto the security word
  assign key_hit  = (cpu_wdata == word_r[{1'b0, kcnt_r} + 3'h1]);
  assign key_last = (kcnt_r == `FSL_KEY_LAST);

  // Counts back-to-back key accesses; any other access restarts
  always_ff @(posedge clk)
  begin
    if (dev_rst)
    begin
      kcnt_r      <= '0;
      kok_r       <= 1'b1;
      bd_unlock_r <= 1'b0;
    end
    else if (cpu_acc && boot_done)
    begin
      if (!cpu_key)
      begin
        kcnt_r <= '0;
        kok_r  <= 1'b1;
      end
      else if (key_last)
      begin
        kcnt_r <= '0;
        kok_r  <= 1'b1;
        if (kok_r && key_hit)
          bd_unlock_r <= 1'b1;
      end
      else
      begin
        kcnt_r <= kcnt_r + 2'h1;
        kok_r  <= kok_r && key_hit;
      end
    end
  end

  // ****************************************
  // Debug gate
  // ****************************************
  // Denied until the boot read of all five words is done, then while secured
  assign secured       = sec_r && !bd_unlock_r;
  assign dbg_en        = boot_done && !secured;
  assign dbg_fl_grant  = dbg_fl_req && dbg_en;
  assign dbg_fl_denied = dbg_fl_req && !dbg_en;

  // ****************************************
  // Checks
  // ****************************************
  chk_boot_blocks: assert property (@(posedge clk) disable iff (!resetn)
    !boot_done |-> !dbg_fl_grant) else $error("debug granted before boot");
  chk_secure_denies: assert property (@(posedge clk) disable iff (!resetn)
    dbg_fl_req && secured |-> dbg_fl_denied && !dbg_fl_grant)
    else $error("debug access while secured");
  chk_sec_eval: assert property (@(posedge clk) disable iff (!resetn)
    boot_r == BOOT_WAIT && fl_rd_ack && idx_r == '0 && dev_rstn
    |=> sec_r == ($past(fl_rd_data) == `FSL_SEC_ON)) else $error("security word misread");
  chk_erase_start: assert property (@(posedge clk) disable iff (!resetn)
    armed_r && tap_r == TAP_IDLE && !erase_fin_r && !erase_busy_r |=> erase_go)
    else $error("erase did not start");
  chk_erase_hold: assert property (@(posedge clk) disable iff (!resetn)
    erase_go && tap_r != TAP_IDLE && !erase_done |=> !erase_go)
    else $error("erase kept running outside idle");
  chk_erase_clear: assert property (@(posedge clk) disable iff (!resetn)
    erase_go && erase_done |=> prot_clr ##1 !prot_clr) else $error("no protection clear");
  chk_key_unlock: assert property (@(posedge clk) disable iff (!resetn)
    dev_rstn && boot_done && cpu_acc && cpu_key && key_last && kok_r && key_hit
    |=> !secured) else $error("good key did not unlock");
  chk_key_reject: assert property (@(posedge clk) disable iff (!resetn)
    dev_rstn && !bd_unlock_r && cpu_acc && cpu_key && key_last && !(kok_r && key_hit)
    |=> !bd_unlock_r) else $error("bad key unlocked");
  chk_prog_clear: assert property (@(posedge clk) disable iff (!resetn)
    dev_rstn && cpu_prog.valid && cpu_prog.addr == `FSL_SEC_ADDR
    |=> (fl_prog.data & ~$past(word_r[0])) == '0) else $error("program set a bit");
  chk_unlock_reset: assert property (@(posedge clk) disable iff (!resetn)
    !dev_rstn |=> !bd_unlock_r && !dbg_en) else $error("unlock survived reset");
  chk_tap_reset: assert property (@(posedge clk) disable iff (!resetn)
    tck_rise && tap_r == TAP_RESET |=> ir_r == `FSL_IR_IDCODE) else $error("ir not idcode");
  cov_erase: cover property (@(posedge clk) disable iff (!resetn) erase_go && erase_done);
  cov_unlock: cover property (@(posedge clk) disable iff (!resetn) $rose(bd_unlock_r));
  cov_denied: cover property (@(posedge clk) disable iff (!resetn) dbg_fl_denied && boot_done);
  cov_grant: cover property (@(posedge clk) disable iff (!resetn) dbg_fl_grant);
endmodule
`default_nettype wire

// file: test/fsl_flash_model.sv
// Behavioural flash array model: boot reads, programming and mass erase
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defs.svh"
module fsl_flash_model
  import fsl_pkg::*;
#(
  parameter int ERASE_CYC = 200
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               fl_rd_req,
  input  wire logic [`FSL_AW-1:0] fl_rd_addr,
  output logic                    fl_rd_ack,
  output logic [`FSL_DW-1:0]      fl_rd_data,
  input  wire fsl_req_t           fl_prog,
  input  wire logic               erase_go,
  output logic                    erase_done
);
  logic [`FSL_DW-1:0] mem [logic [`FSL_AW-1:0]]; // Contents never reset
  logic [`FSL_AW-1:0] addr_q;
  logic               busy;
  logic               slow;
  int                 cnt;
  int                 ecnt;

  // Erased cells read as all ones
  function automatic logic [`FSL_DW-1:0] rd(input logic [`FSL_AW-1:0] a);
    return mem.exists(a) ? mem[a] : `FSL_ERASED;
  endfunction

  // Preload a word before the run
  task automatic set(input logic [`FSL_AW-1:0] a, input logic [`FSL_DW-1:0] v);
    mem[a] = v;
  endtask

  // Start values of the model's outputs
  initial
  begin
    fl_rd_ack  = 1'b0;
    fl_rd_data = 16'h5A5A;
    erase_done = 1'b0;
    busy       = 1'b0;
    slow       = 1'b0;
  end

  // Boot reads answered alternately promptly and slowly; idle data toggles
  always @(posedge clk)
  begin
    fl_rd_ack  <= 1'b0;
    fl_rd_data <= ~fl_rd_data;
    if (!rst_n)
      busy <= 1'b0;
    else if (busy && cnt == 0)
    begin
      fl_rd_ack  <= 1'b1;
      fl_rd_data <= rd(addr_q);
      busy       <= 1'b0;
    end
    else if (busy)
      cnt <= cnt - 1;
    else if (fl_rd_req)
    begin
      busy   <= 1'b1;
      addr_q <= fl_rd_addr;
      cnt    <= slow ? 3 : 0;
      slow   <= ~slow;
    end
  end

  // Programming only clears bits; a running erase wipes the array
  always @(posedge clk)
  begin
    erase_done <= 1'b0;
    if (fl_prog.valid)
      mem[fl_prog.addr] = rd(fl_prog.addr) & fl_prog.data;
    if (!erase_go)
      ecnt <= 0;
    else if (ecnt == ERASE_CYC - 1)
    begin
      mem.delete();
      erase_done <= 1'b1;
      ecnt       <= 0;
    end
    else
      ecnt <= ecnt + 1;
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking testbench for the flash security interlock
`timescale 1ns/10ps
`default_nettype none
`include "fsl_defs.svh"
module tb
  import fsl_pkg::*;
;
  localparam logic [63:0] KEY = 64'hDEF0_9ABC_5678_1234;
  logic                   clk, resetn, dev_rstn, tck, tms, tdi, tdo, tdo_oe_n;
  logic [`FSL_BSR_W-1:0]  bsr_pins;
  logic                   fl_rd_req, fl_rd_ack, erase_go, erase_done, prot_clr;
  logic [`FSL_AW-1:0]     fl_rd_addr;
  logic [`FSL_DW-1:0]     fl_rd_data, cpu_wdata;
  fsl_req_t               cpu_prog, fl_prog;
  logic [`FSL_DIV_W-1:0]  erase_div;
  logic                   cpu_acc, cpu_key, dbg_fl_req, dbg_fl_grant, dbg_fl_denied;
  logic                   dbg_en, secured;
  wire logic              flash_rst_n;
  int                     miscompares, n_compared;

  assign flash_rst_n = resetn & dev_rstn;

  fsl_lockout i_dut (.clk(clk), .resetn(resetn), .dev_rstn(dev_rstn), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .bsr_pins(bsr_pins), .fl_rd_req(fl_rd_req),
    .fl_rd_addr(fl_rd_addr), .fl_rd_ack(fl_rd_ack), .fl_rd_data(fl_rd_data),
    .cpu_prog(cpu_prog), .fl_prog(fl_prog), .erase_go(erase_go), .erase_div(erase_div),
    .erase_done(erase_done), .prot_clr(prot_clr), .cpu_acc(cpu_acc), .cpu_key(cpu_key),
    .cpu_wdata(cpu_wdata), .dbg_fl_req(dbg_fl_req), .dbg_fl_grant(dbg_fl_grant),
    .dbg_fl_denied(dbg_fl_denied), .dbg_en(dbg_en), .secured(secured));

  fsl_flash_model i_flash (.clk(clk), .rst_n(flash_rst_n), .fl_rd_req(fl_rd_req),
    .fl_rd_addr(fl_rd_addr), .fl_rd_ack(fl_rd_ack), .fl_rd_data(fl_rd_data),
    .fl_prog(fl_prog), .erase_go(erase_go), .erase_done(erase_done));

  // System clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ***************************************************************
  // Checking and closing
  // ***************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task final_report;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk_sec(input logic s);
    chk("secured", secured, s);
    chk("dbg_en", dbg_en, !s);
    chk("dbg_grant", dbg_fl_grant, !s);
    chk("dbg_denied", dbg_fl_denied, s);
    @(posedge clk);
    dbg_fl_req <= 1'b0;
    @(posedge clk);
    #1;
    chk("dbg_idle", {dbg_fl_grant, dbg_fl_denied}, 2'h0);
    chk("dbg_en_idle", dbg_en, !s);
    @(posedge clk);
    dbg_fl_req <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  // ***************************************************************
  // Reset, boot and bus helpers
  // ***************************************************************
  task boot_wait;
    int n, k;
    n = 0;
    for (k = 0; k < 300 && n < 5; k++)
    begin
      @(posedge clk);
      #1;
      chk("grant_in_boot", dbg_fl_grant, 1'b0);
      if (fl_rd_req === 1'b1 && n == 0)
        chk("boot_addr", fl_rd_addr, `FSL_SEC_ADDR);
      else if (fl_rd_req === 1'b1)
        chk("key_addr", fl_rd_addr, `FSL_KEY_BASE + n - 1);
      if (fl_rd_ack === 1'b1)
        n++;
    end
    chk("boot_reads", n, 5);
    @(posedge clk);
    #1;
  endtask

  task do_reset(input bit por);
    @(posedge clk);
    if (por)
      resetn <= 1'b0;
    else
      dev_rstn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn   <= 1'b1;
    dev_rstn <= 1'b1;
    boot_wait();
  endtask

  // One TCK period of sixteen system clocks; TDO read before the rise
  task jbit(input logic m, input logic d, output logic o);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    o = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // From Run-Test/Idle through a shift, LSB first, back to Run-Test/Idle
  task jshift(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    int   i;
    dout = '0;
    jbit(1'b1, 1'b0, o);
    if (ir)
      jbit(1'b1, 1'b0, o);
    jbit(1'b0, 1'b0, o);
    jbit(1'b0, 1'b0, o);
    for (i = 0; i < n; i++)
    begin
      jbit(i == n - 1, din[i], o);
      dout[i] = o;
      chk("tdo_oe_n", tdo_oe_n, 1'b0);
    end
    jbit(1'b1, 1'b0, o);
    jbit(1'b0, 1'b0, o);
  endtask

  task key_send(input logic [63:0] k, input bit brk);
    int i;
    @(posedge clk);
    cpu_acc <= 1'b1;
    cpu_key <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      if (brk && i == 2)
      begin
        cpu_key <= 1'b0;
        @(posedge clk);
      end
      cpu_key   <= 1'b1;
      cpu_wdata <= k[16*i +: 16];
    end
    @(posedge clk);
    cpu_acc <= 1'b0;
    cpu_key <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task prog(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    cpu_prog <= '{valid: 1'b1, addr: a, data: d};
    @(posedge clk);
    cpu_prog <= '0;
    #1;
    chk("fl_prog_valid", fl_prog.valid, 1'b1);
    chk("fl_prog_addr", fl_prog.addr, a);
    chk("fl_prog_data", fl_prog.data, exp);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task t_boot_secured;
    logic [31:0] d;
    logic        o;
    chk_sec(1'b1);
    jbit(1'b0, 1'b0, o);
    jshift(1'b1, `FSL_IR_W, `FSL_IR_IDCODE, d);
    jshift(1'b0, `FSL_ID_W, 32'h0, d);
    chk("idcode", d, `FSL_IDCODE_VAL);
    jshift(1'b1, `FSL_IR_W, `FSL_IR_SAMPLE, d);
    jshift(1'b0, `FSL_BSR_W, 32'h0, d);
    chk("sample", d, 32'h0000_00A5);
  endtask

  task t_key;
    key_send(KEY ^ 64'h1, 1'b0);
    chk_sec(1'b1);
    chk("key_word_kept", i_flash.rd(16'h1FFC), 16'h1234);
    key_send(KEY, 1'b1);
    chk_sec(1'b1);
    key_send(KEY, 1'b0);
    chk_sec(1'b0);
    do_reset(1'b0);
    chk_sec(1'b1);
  endtask

  task t_erase;
    logic [31:0] d;
    int          k;
    jshift(1'b1, `FSL_IR_W, `FSL_IR_ERASE, d);
    jshift(1'b0, `FSL_DIV_W, 32'h55, d);
    for (k = 0; k < 40 && erase_go !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk("erase_go", erase_go, 1'b1);
    chk("erase_div", erase_div, 7'h55);
    for (k = 0; k < 400 && erase_done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    chk("prot_clr_pulse", prot_clr, 1'b1);
    @(posedge clk);
    #1;
    chk("prot_clr_end", prot_clr, 1'b0);
    chk("erase_go_end", erase_go, 1'b0);
    chk_sec(1'b1);
    do_reset(1'b1);
    chk_sec(1'b0);
  endtask

  task t_prog;
    prog(`FSL_SEC_ADDR, `FSL_SEC_ON, `FSL_SEC_ON);
    do_reset(1'b0);
    chk_sec(1'b1);
    prog(`FSL_SEC_ADDR, `FSL_SEC_OFF, `FSL_SEC_OFF);
    prog(`FSL_SEC_ADDR, `FSL_ERASED, `FSL_SEC_OFF);
    prog(16'h0100, 16'h00F0, 16'h00F0);
    do_reset(1'b0);
    chk_sec(1'b0);
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // Main sequence
  initial
  begin
    miscompares = 0;
    n_compared  = 0;
    resetn      = 1'b0;
    dev_rstn    = 1'b1;
    tck         = 1'b1;
    tms         = 1'b1;
    tdi         = 1'b0;
    bsr_pins    = 8'hA5;
    cpu_prog    = '0;
    cpu_acc     = 1'b0;
    cpu_key     = 1'b0;
    cpu_wdata   = 16'h0000;
    dbg_fl_req  = 1'b1;
    i_flash.set(`FSL_SEC_ADDR, `FSL_SEC_ON);
    i_flash.set(16'h1FFC, KEY[15:0]);
    i_flash.set(16'h1FFD, KEY[31:16]);
    i_flash.set(16'h1FFE, KEY[47:32]);
    i_flash.set(16'h1FFF, KEY[63:48]);
    do_reset(1'b1);
    t_boot_secured();
    t_key();
    t_erase();
    t_prog();
    final_report();
  end
endmodule
`default_nettype wire
